/* File: core/switch_global_frame_vlan_control.v */
// Switch global frame size, VLAN, sniff and port 4 control registers
`timescale 1ns/1ns
`default_nettype none
`include "switch_global_defs.vh"

module switch_global_frame_vlan_control #(
   parameter LEN_W = 11
) (
   input  wire             clk,
   input  wire             nrst,
   input  wire             smi_mdc,
   input  wire             smi_mdio_in,
   output reg              smi_mdio_out,
   output reg              smi_mdio_oe,
   input  wire             port_receive_bit2_strap_pin,
   input  wire             fwd_req,
   input  wire [LEN_W-1:0] fwd_frame_len,
   input  wire             fwd_tagged,
   input  wire             fwd_special_cpu_tag_id,
   input  wire             fwd_is_igmp,
   input  wire [11:0]      fwd_vid,
   input  wire             fwd_src_match,
   input  wire             fwd_dst_match,
   output reg              fwd_done,
   output reg              fwd_accept,
   output reg              fwd_to_port4,
   output reg              fwd_tag_mask_valid,
   output reg  [4:0]       fwd_tag_dest_mask,
   output reg              fwd_mirror,
   output reg              vlan_mode,
   output reg              direct_mode_port4,
   output reg              pretag_port4,
   output reg              backpressure_port4,
   output reg              half_duplex_port4
);

   // ****************************************************************
   // State encoding
   // ****************************************************************
   localparam [3:0] S_PRE  = 4'h1;
   localparam [3:0] S_HDR  = 4'h2;
   localparam [3:0] S_TA   = 4'h4;
   localparam [3:0] S_DATA = 4'h8;

   // ****************************************************************
   // Control bits
   // ****************************************************************
   reg huge_frame_reg;
   reg size_check_off_reg;
   reg vlan_en_reg;
   reg igmp_snoop_reg;
   reg direct_mode_reg;
   reg pretag_reg;
   reg tag_mask_reg;
   reg sniff_and_reg;
   reg bp_en_reg;
   reg half_duplex_reg;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   reg [1:0] mdc_sync_reg;
   reg [1:0] mdio_sync_reg;
   reg [1:0] strap_sync_reg;
   reg       mdc_prev_reg;
   reg [1:0] strap_cnt_reg;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mdc_sync_reg   <= 2'h0;
         mdio_sync_reg  <= 2'h3;
         strap_sync_reg <= 2'h0;
         mdc_prev_reg   <= 1'b0;
      end else begin
         mdc_sync_reg   <= {mdc_sync_reg[0], smi_mdc};
         mdio_sync_reg  <= {mdio_sync_reg[0], smi_mdio_in};
         strap_sync_reg <= {strap_sync_reg[0], port_receive_bit2_strap_pin};
         mdc_prev_reg   <= mdc_sync_reg[1];
      end
   end

   wire mdc_rise = mdc_sync_reg[1] & ~mdc_prev_reg;
   wire mdio_bit = mdio_sync_reg[1];

   // ****************************************************************
   // Register read decode
   // ****************************************************************
   // Reserved bits are hard zero here
   function [7:0] reg_value;
      input [7:0] addr;
      begin
         case (addr)
            `OFF_FRAME_SIZE:
               reg_value = {5'h00, huge_frame_reg,
                            size_check_off_reg, 1'b0};
            `OFF_VLAN_SNOOP:
               reg_value = {vlan_en_reg, igmp_snoop_reg,
                            direct_mode_reg, pretag_reg, 2'h0,
                            tag_mask_reg, sniff_and_reg};
            `OFF_PORT4_DUPLEX:
               reg_value = {bp_en_reg, half_duplex_reg, 6'h00};
            default:
               reg_value = 8'h00;
         endcase
      end
   endfunction

   // ****************************************************************
   // Management frame engine
   // ****************************************************************
   reg [3:0]  state_reg;
   reg [5:0]  ones_cnt_reg;
   reg [4:0]  bit_cnt_reg;
   reg [12:0] hdr_reg;
   reg [15:0] shift_reg;
   reg        is_read_reg;
   reg [7:0]  addr_reg;
   reg        wr_pulse_reg;

   wire [12:0] hdr_full = {hdr_reg[11:0], mdio_bit};

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg    <= S_PRE;
         ones_cnt_reg <= 6'h00;
         bit_cnt_reg  <= 5'h00;
         hdr_reg      <= 13'h0000;
         shift_reg    <= 16'h0000;
         is_read_reg  <= 1'b0;
         addr_reg     <= 8'h00;
         wr_pulse_reg <= 1'b0;
         smi_mdio_out <= 1'b0;
         smi_mdio_oe  <= 1'b0;
      end else begin
         wr_pulse_reg <= 1'b0;
         if (mdc_rise) begin
            case (state_reg)
               S_PRE: begin
                  smi_mdio_oe <= 1'b0;
                  if (mdio_bit) begin
                     if (ones_cnt_reg != `SMI_PREAMBLE_ONES)
                        ones_cnt_reg <= ones_cnt_reg + 6'h01;
                  end else begin
                     // Zero after full preamble is start bit one
                     if (ones_cnt_reg == `SMI_PREAMBLE_ONES) begin
                        state_reg   <= S_HDR;
                        bit_cnt_reg <= 5'h00;
                     end
                     ones_cnt_reg <= 6'h00;
                  end
               end
               S_HDR: begin
                  hdr_reg     <= hdr_full;
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  if (bit_cnt_reg == `SMI_HDR_BITS - 5'h01) begin
                     // Start 1, op 2, phy 5, reg 5
                     addr_reg    <= {hdr_full[7:5], hdr_full[4:0]};
                     is_read_reg <= (hdr_full[11:10] == `SMI_OP_READ);
                     bit_cnt_reg <= 5'h00;
                     if (hdr_full[12] &&
                         (hdr_full[11:10] == `SMI_OP_READ ||
                          hdr_full[11:10] == `SMI_OP_WRITE))
                        state_reg <= S_TA;
                     else
                        state_reg <= S_PRE;
                  end
               end
               S_TA: begin
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  if (bit_cnt_reg == 5'h00) begin
                     if (is_read_reg) begin
                        smi_mdio_oe  <= 1'b1;
                        smi_mdio_out <= 1'b0;
                        shift_reg    <= {8'h00, reg_value(addr_reg)};
                     end
                  end else begin
                     state_reg   <= S_DATA;
                     bit_cnt_reg <= 5'h00;
                     if (is_read_reg) begin
                        smi_mdio_out <= shift_reg[15];
                        shift_reg    <= {shift_reg[14:0], 1'b0};
                     end
                  end
               end
               S_DATA: begin
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  if (is_read_reg) begin
                     smi_mdio_out <= shift_reg[15];
                     shift_reg    <= {shift_reg[14:0], 1'b0};
                  end else begin
                     shift_reg <= {shift_reg[14:0], mdio_bit};
                  end
                  if (bit_cnt_reg == `SMI_DATA_BITS - 5'h01) begin
                     // Read driver stays on, driving zero, until the next edge
                     state_reg    <= S_PRE;
                     ones_cnt_reg <= 6'h00;
                     wr_pulse_reg <= ~is_read_reg;
                     if (!is_read_reg)
                        smi_mdio_oe <= 1'b0;
                  end
               end
               default: begin
                  state_reg   <= S_PRE;
                  smi_mdio_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Register writes and strap capture
   // ****************************************************************
   wire [7:0] wr_data = shift_reg[7:0];

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         huge_frame_reg     <= 1'b0;
         size_check_off_reg <= 1'b0;
         vlan_en_reg        <= 1'b0;
         igmp_snoop_reg     <= 1'b0;
         direct_mode_reg    <= 1'b0;
         pretag_reg         <= 1'b0;
         tag_mask_reg       <= 1'b0;
         sniff_and_reg      <= 1'b0;
         bp_en_reg          <= 1'b0;
         half_duplex_reg    <= 1'b0;
         strap_cnt_reg      <= 2'h0;
      end else begin
         // Strap is stable only after the chain has filled
         if (strap_cnt_reg != `STRAP_SETTLE + 2'h1)
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == `STRAP_SETTLE)
            half_duplex_reg <= strap_sync_reg[1];
         if (wr_pulse_reg) begin
            case (addr_reg)
               `OFF_FRAME_SIZE: begin
                  huge_frame_reg     <= wr_data[`BIT_HUGE_FRAME];
                  size_check_off_reg <= wr_data[`BIT_SIZE_CHECK_OFF];
               end
               `OFF_VLAN_SNOOP: begin
                  vlan_en_reg     <= wr_data[`BIT_VLAN_EN];
                  igmp_snoop_reg  <= wr_data[`BIT_IGMP_SNOOP];
                  direct_mode_reg <= wr_data[`BIT_DIRECT_MODE];
                  pretag_reg      <= wr_data[`BIT_PRETAG];
                  tag_mask_reg    <= wr_data[`BIT_TAG_MASK];
                  sniff_and_reg   <= wr_data[`BIT_SNIFF_AND];
               end
               `OFF_PORT4_DUPLEX: begin
                  bp_en_reg       <= wr_data[`BIT_BP_EN];
                  half_duplex_reg <= wr_data[`BIT_HALF_DUPLEX];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Frame decisions
   // ****************************************************************
   reg [LEN_W-1:0] len_limit;

   always @* begin
      if (huge_frame_reg)
         len_limit = `LEN_HUGE;
      else if (size_check_off_reg)
         len_limit = `LEN_NO_CHECK;
      else if (fwd_tagged && !fwd_special_cpu_tag_id)
         len_limit = `LEN_TAGGED;
      else if (fwd_tagged)
         len_limit = `LEN_NO_CHECK;
      else
         len_limit = `LEN_UNTAGGED;
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fwd_done           <= 1'b0;
         fwd_accept         <= 1'b0;
         fwd_to_port4       <= 1'b0;
         fwd_tag_mask_valid <= 1'b0;
         fwd_tag_dest_mask  <= 5'h00;
         fwd_mirror         <= 1'b0;
         vlan_mode          <= 1'b0;
         direct_mode_port4  <= 1'b0;
         pretag_port4       <= 1'b0;
         backpressure_port4 <= 1'b0;
         half_duplex_port4  <= 1'b0;
      end else begin
         vlan_mode          <= vlan_en_reg;
         direct_mode_port4  <= direct_mode_reg;
         pretag_port4       <= pretag_reg;
         backpressure_port4 <= bp_en_reg;
         half_duplex_port4  <= half_duplex_reg;
         fwd_done           <= fwd_req;
         if (fwd_req) begin
            fwd_accept   <= (fwd_frame_len <= len_limit);
            fwd_to_port4 <= igmp_snoop_reg & fwd_is_igmp;
            // Mask ignored while 802.1q mode owns forwarding
            fwd_tag_mask_valid <= tag_mask_reg & ~vlan_en_reg;
            fwd_tag_dest_mask  <= (tag_mask_reg & ~vlan_en_reg) ?
                                  fwd_vid[4:0] : 5'h00;
            if (sniff_and_reg)
               fwd_mirror <= fwd_src_match & fwd_dst_match;
            else
               fwd_mirror <= fwd_src_match | fwd_dst_match;
         end
      end
   end

endmodule // switch_global_frame_vlan_control
`default_nettype wire

/* File: core/switch_global_defs.vh */
// Constants for the switch global frame, VLAN and port 4 control block
`ifndef SWITCH_GLOBAL_DEFS_VH
`define SWITCH_GLOBAL_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFF_FRAME_SIZE     8'h04
`define OFF_VLAN_SNOOP     8'h05
`define OFF_PORT4_DUPLEX   8'h06

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_HUGE_FRAME     2
`define BIT_SIZE_CHECK_OFF 1
`define BIT_VLAN_EN        7
`define BIT_IGMP_SNOOP     6
`define BIT_DIRECT_MODE    5
`define BIT_PRETAG         4
`define BIT_TAG_MASK       1
`define BIT_SNIFF_AND      0
`define BIT_BP_EN          7
`define BIT_HALF_DUPLEX    6

// ****************************************************************
// Frame size limits in bytes
// ****************************************************************
`define LEN_HUGE           11'h077C
`define LEN_NO_CHECK       11'h0600
`define LEN_TAGGED         11'h05F2
`define LEN_UNTAGGED       11'h05EE

// ****************************************************************
// Management frame timing
// ****************************************************************
`define SMI_PREAMBLE_ONES  6'h20
`define SMI_HDR_BITS       5'h0D
`define SMI_TA_BITS        5'h02
`define SMI_DATA_BITS      5'h10
`define SMI_OP_READ        2'h2
`define SMI_OP_WRITE       2'h1
`define STRAP_SETTLE       2'h2

`endif

/* File: test/switch_global_asserts.sv */
// Checker for the frame decision outputs of the global control block
`timescale 1ns/1ns
`default_nettype none
module switch_global_asserts #(
   parameter int LEN_W = 11
) (
   input wire logic             clk,
   input wire logic             nrst,
   input wire logic             fwd_req,
   input wire logic [LEN_W-1:0] fwd_frame_len,
   input wire logic [11:0]      fwd_vid,
   input wire logic             fwd_is_igmp,
   input wire logic             fwd_src_match,
   input wire logic             fwd_dst_match,
   input wire logic             fwd_done,
   input wire logic             fwd_accept,
   input wire logic             fwd_to_port4,
   input wire logic             fwd_tag_mask_valid,
   input wire logic [4:0]       fwd_tag_dest_mask,
   input wire logic             fwd_mirror,
   input wire logic             vlan_mode
);
   // ****************************************
   // Decision timing and results
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_req_both;
      fwd_req && fwd_src_match && fwd_dst_match;
   endsequence
   sequence s_req_none;
      fwd_req && !fwd_src_match && !fwd_dst_match;
   endsequence
   chk_done_after_req: assert property (fwd_req |=> fwd_done)
      else $error("decision not answered one cycle after request");
   chk_no_stray_done: assert property (!fwd_req |=> !fwd_done)
      else $error("done without a request");
   chk_small_accept: assert property (
      fwd_req && fwd_frame_len <= 11'h05EE |=> fwd_accept)
      else $error("frame of legal size dropped");
   chk_huge_ceiling: assert property (
      fwd_req && fwd_frame_len > 11'h077C |=> !fwd_accept)
      else $error("frame above the largest limit accepted");
   chk_igmp_only: assert property (
      fwd_req && !fwd_is_igmp |=> !fwd_to_port4)
      else $error("non IGMP frame steered to port 4");
   chk_mirror_both: assert property (s_req_both |=> fwd_mirror)
      else $error("frame matching both ends not mirrored");
   chk_mirror_none: assert property (s_req_none |=> !fwd_mirror)
      else $error("frame matching neither end mirrored");
   chk_mask_value: assert property (
      fwd_done && fwd_tag_mask_valid
      |-> fwd_tag_dest_mask == $past(fwd_vid[4:0]))
      else $error("tag mask differs from VID low bits");
   chk_mask_vlan_off: assert property (
      fwd_req ##1 vlan_mode |-> !fwd_tag_mask_valid)
      else $error("tag mask active in VLAN mode");
   // Results only move on a new request
   chk_result_hold: assert property (!fwd_req |=>
      $stable({fwd_accept, fwd_mirror, fwd_to_port4, fwd_tag_mask_valid}))
      else $error("decision results changed without a request");
endmodule // switch_global_asserts
bind switch_global_frame_vlan_control switch_global_asserts #(
   .LEN_W(LEN_W)) chk_i (.*);
`default_nettype wire

/* File: test/switch_global_frame_vlan_control_tb_top.sv */
// Testbench for the global frame, VLAN and port 4 control block
`timescale 1ns/1ns
`default_nettype none
module switch_global_frame_vlan_control_tb_top;
   logic clk = 0, nrst = 0, smi_mdc = 0, port_receive_bit2_strap_pin = 0;
   logic host_oe = 1, host_val = 1, smi_mdio_out, smi_mdio_oe;
   logic fwd_req = 0, fwd_tagged = 0, fwd_special_cpu_tag_id = 0;
   logic fwd_is_igmp = 0, fwd_src_match = 0, fwd_dst_match = 0;
   logic [10:0] fwd_frame_len = 11'h0000;
   logic [11:0] fwd_vid = 12'h000;
   logic fwd_done, fwd_accept, fwd_to_port4, fwd_tag_mask_valid, fwd_mirror;
   logic [4:0] fwd_tag_dest_mask;
   logic vlan_mode, direct_mode_port4, pretag_port4;
   logic backpressure_port4, half_duplex_port4;
   logic [7:0] r04 = 8'h00, r05 = 8'h00;
   logic [15:0] q = 16'h0000;
   int bad_count = 0, n_tests = 0;
   // Idle MDIO floats high through its pull-up
   wire logic smi_mdio_in = smi_mdio_oe ? smi_mdio_out
                                        : (host_oe ? host_val : 1'b1);
   logic [23:0] regs [4] = '{24'h04_FF06, 24'h05_FFF3, 24'h06_FFC0,
                             24'h07_FF00};
   logic [29:0] rows [11] = '{{16'h0000, 11'h05EE, 3'b001},
      {16'h0000, 11'h05EF, 3'b000}, {16'h0001, 11'h05F2, 3'b101},
      {16'h0001, 11'h05F3, 3'b100}, {16'h0040, 11'h0600, 3'b111},
      {16'h0040, 11'h0601, 3'b110}, {16'h0202, 11'h0600, 3'b001},
      {16'h0202, 11'h0601, 3'b100}, {16'h0682, 11'h077C, 3'b101},
      {16'h04C3, 11'h077D, 3'b000}, {16'h0442, 11'h077C, 3'b001}};

   always #4 clk = ~clk;
   switch_global_frame_vlan_control dut (
      .clk(clk), .nrst(nrst), .smi_mdc(smi_mdc),
      .smi_mdio_in(smi_mdio_in), .smi_mdio_out(smi_mdio_out),
      .smi_mdio_oe(smi_mdio_oe),
      .port_receive_bit2_strap_pin(port_receive_bit2_strap_pin),
      .fwd_req(fwd_req), .fwd_frame_len(fwd_frame_len),
      .fwd_tagged(fwd_tagged),
      .fwd_special_cpu_tag_id(fwd_special_cpu_tag_id),
      .fwd_is_igmp(fwd_is_igmp), .fwd_vid(fwd_vid),
      .fwd_src_match(fwd_src_match), .fwd_dst_match(fwd_dst_match),
      .fwd_done(fwd_done), .fwd_accept(fwd_accept),
      .fwd_to_port4(fwd_to_port4),
      .fwd_tag_mask_valid(fwd_tag_mask_valid),
      .fwd_tag_dest_mask(fwd_tag_dest_mask), .fwd_mirror(fwd_mirror),
      .vlan_mode(vlan_mode), .direct_mode_port4(direct_mode_port4),
      .pretag_port4(pretag_port4),
      .backpressure_port4(backpressure_port4),
      .half_duplex_port4(half_duplex_port4));

   // ****************************************
   // Helper tasks
   // ****************************************
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp_bit(input logic g, input logic e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: bit %b not %b", $time, g, e);
      end
   endtask
   task automatic cmp_val(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: value %h not %h", $time, g, e);
      end
   endtask
   // MDC at 160 ns: well clear of the 4 clk sampling minimum
   task automatic smi(input logic [1:0] op, input logic [7:0] a,
                      input logic [15:0] d);
      logic [64:0] f;
      f = {32'hFFFF_FFFF, 2'b01, op, 2'b00, a, 2'b10, d, 1'b1};
      for (int i = 64; i >= 0; i--) begin
         @(negedge clk);
         smi_mdc = 1'b0;
         host_val = f[i];
         host_oe = !(op == 2'h2 && i >= 1 && i <= 18);
         repeat (10) @(negedge clk);
         if (i >= 1 && i <= 16)
            q[i-1] = smi_mdio_in;
         smi_mdc = 1'b1;
         repeat (9) @(negedge clk);
      end
      repeat (10) @(negedge clk);
      smi_mdc = 1'b0;
      host_oe = 1'b1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      smi(2'h1, a, {8'h00, d});
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      smi(2'h2, a, 16'h0000);
      cmp_val(q, e);
   endtask
   task automatic do_reset(input logic s);
      @(negedge clk);
      nrst = 1'b0;
      port_receive_bit2_strap_pin = s;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (8) @(negedge clk);
   endtask
   task automatic frame(input logic [10:0] len, input logic tg, cp, acc);
      logic v;
      @(negedge clk);
      {fwd_req, fwd_frame_len, fwd_tagged} = {1'b1, len, tg};
      fwd_special_cpu_tag_id = cp;
      {fwd_is_igmp, fwd_src_match, fwd_dst_match} = len[2:0];
      fwd_vid = {1'b1, len};
      @(negedge clk);
      fwd_req = 1'b0;
      v = r05[1] & ~r05[7];
      cmp_bit(fwd_done, 1'b1);
      cmp_bit(fwd_accept, acc);
      cmp_bit(fwd_to_port4, r05[6] & len[2]);
      cmp_bit(fwd_mirror, r05[0] ? &len[1:0] : |len[1:0]);
      cmp_bit(fwd_tag_mask_valid, v);
      cmp_val({11'h000, fwd_tag_dest_mask}, v ? len[4:0] : 16'h0000);
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (80000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      do_reset(1'b0);
      cmp_val({vlan_mode, direct_mode_port4, pretag_port4,
               backpressure_port4, half_duplex_port4}, 16'h0000);
      rd(8'h04, 16'h0000);
      rd(8'h05, 16'h0000);
      rd(8'h06, 16'h0000);
      foreach (regs[k]) begin
         wr(regs[k][23:16], regs[k][15:8]);
         rd(regs[k][23:16], {8'h00, regs[k][7:0]});
      end
      cmp_val({vlan_mode, direct_mode_port4, pretag_port4,
               backpressure_port4, half_duplex_port4},
              16'h001F);
      {r04, r05} = 16'h06F3;
      foreach (rows[k]) begin
         if (rows[k][29:14] !== {r04, r05}) begin
            {r04, r05} = rows[k][29:14];
            wr(8'h04, r04);
            wr(8'h05, r05);
         end
         frame(rows[k][13:3], rows[k][2], rows[k][1], rows[k][0]);
      end
      // Back to back requests, reject then accept
      @(negedge clk);
      {fwd_req, fwd_frame_len} = {1'b1, 11'h077D};
      @(negedge clk);
      fwd_frame_len = 11'h077C;
      cmp_bit(fwd_accept, 1'b0);
      @(negedge clk);
      fwd_req = 1'b0;
      cmp_bit(fwd_accept, 1'b1);
      // Illegal opcode must leave the register alone
      smi(2'h0, 8'h05, 16'h0000);
      rd(8'h05, 16'h0042);
      do_reset(1'b1);
      cmp_bit(half_duplex_port4, 1'b1);
      cmp_bit(vlan_mode, 1'b0);
      rd(8'h06, 16'h0040);
      end_of_test();
   end
endmodule // switch_global_frame_vlan_control_tb_top
`default_nettype wire
